// ### hdl/gsr_consts.vh
`ifndef GSR_CONSTS_VH
`define GSR_CONSTS_VH

// Register byte offsets.
`define GSR_OFF_CTRL 8'h00
`define GSR_OFF_STATUS 8'h04
`define GSR_OFF_STB 8'h08
`define GSR_OFF_POST 8'h0C
`define GSR_OFF_TOP 8'h10

// Control field positions and reset values.
`define GSR_CTRL_SRQ_EN 0
`define GSR_CTRL_DONE_EN 1
`define GSR_RST_SRQ_EN 1'b1
`define GSR_RST_DONE_EN 1'b1

// Event store depth.
`define GSR_DEPTH 4'hA

// Status byte values.
`define GSR_STB_NONE 8'h00
`define GSR_STB_PON 8'h41
`define GSR_STB_DONE 8'h42
`define GSR_STB_USER 8'h43
`define GSR_STB_PRINT 8'h44
`define GSR_STB_RECOV 8'h45
`define GSR_STB_CMD 8'h61
`define GSR_STB_EXEC 8'h62
`define GSR_STB_INT 8'h63
`define GSR_STB_DEV 8'hC0
`define GSR_STB_SRQ_BIT 8'h40

// Event codes.
`define GSR_EV_NONE 10'h000
`define GSR_EV_PON 10'h191
`define GSR_EV_MEAS 10'h192
`define GSR_EV_USER 10'h193
`define GSR_EV_PRINT 10'h194
`define GSR_EV_RECOV 10'h195
`define GSR_EV_SWEEP 10'h196
`define GSR_EV_DISK 10'h197
`define GSR_EV_LRS 10'h2E6
`define GSR_EV_ILOCK 10'h2EE
`define GSR_EV_BRKR 10'h2EF
`define GSR_EV_DISK2 10'h2F1
`define GSR_EV_RESUME 10'h2F2

// Event code range bounds for the error categories.
`define GSR_EV_100 10'h064
`define GSR_EV_200 10'h0C8
`define GSR_EV_300 10'h12C
`define GSR_EV_400 10'h190
`define GSR_EV_700 10'h2BC
`define GSR_EV_800 10'h320

`endif

// ### hdl/gsr_reporter.v
// Summary of operation
// - Request line rises whenever an error or status change is waiting to be reported.
// - A serial poll returns the status byte naming the category of the event.
// - The request is withdrawn once its status byte has been returned to a poll.
// - With further events waiting, the request rises again after each poll.
// - An event query returns the numeric code of the specific condition.
// - Only the status byte awaiting a poll plus the latest pending byte are kept.
// - Event codes sit in a ten-deep last-in-first-out store; queries pop the newest.
// - With request enable off, the line stays low but ten codes still accumulate.
// - The request enable masks every request; operation-complete requests are also masked by their own enable.
// - With operation-complete enable on, each finished operation raises a request.
// - Reading the enables returns only their on or off state.
// - Byte holds category in low bits, abnormal flag, and request bit under enable.
// - No event gives byte zero; power-on 65, completion 66, user 67, recovery 69.
// - After reset a power-on status with event code 401 is reported.
// - Command error codes 101 to 109 report status 97.
// - Execution error codes 201 to 250 report status 98.
// - Internal error codes 303 to 350 report status 99.
// - Device events 7xx report status 192; only 742, 750, 751, 753 and 754 fall under the operation-complete mask.
// - Codes 402 and 406 report 66 under the mask; printer done reports 404.
// - Single button pressed while fast/shift is held raises user request 403.
// - Clearing a phase-lock or overheat fault raises collector recovery 405.
`timescale 1ns/10ps
`include "gsr_consts.vh"

module gsr_reporter (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Controller side
    output wire srq,
    input wire spoll_req,
    output reg [7:0] spoll_byte,
    output reg spoll_valid,
    input wire evq_req,
    output reg [9:0] evq_code,
    output reg evq_valid,
    // Instrument event sources
    input wire meas_done,
    input wire sweep_done,
    input wire print_done,
    input wire single_btn,
    input wire fast_shift_btn,
    input wire pll_fault,
    input wire overheat_fault
);

    localparam NSRC = 7;

    reg srq_en_r;
    reg done_en_r;
    wire [NSRC-1:0] pend_r;
    reg [9:0] post_code_r;
    reg single_prev_r;
    reg pll_prev_r;
    reg heat_prev_r;
    reg cur_v_r;
    reg [7:0] cur_r;
    reg pend_v_r;
    reg [7:0] pnd_r;
    reg gap_r;
    reg [3:0] cnt_r;
    reg cur_v_nxt;
    reg [7:0] cur_nxt;
    reg pend_v_nxt;
    reg [7:0] pnd_nxt;
    reg [9:0] ev_code;
    reg ev_fire;
    reg [NSRC-1:0] pick;
    reg [31:0] rd_nxt;
    reg addr_ok;
    integer k;
    wire [9:0] top_code;

    // Codes outside every known range get no status byte but are still stored.
    function [7:0] cat_of;
        input [9:0] c;
        begin
            if (c == `GSR_EV_PON) begin
                cat_of = `GSR_STB_PON;
            end else if (c == `GSR_EV_MEAS || c == `GSR_EV_SWEEP || c == `GSR_EV_DISK) begin
                cat_of = `GSR_STB_DONE;
            end else if (c == `GSR_EV_USER) begin
                cat_of = `GSR_STB_USER;
            end else if (c == `GSR_EV_PRINT) begin
                cat_of = `GSR_STB_PRINT;
            end else if (c == `GSR_EV_RECOV) begin
                cat_of = `GSR_STB_RECOV;
            end else if (c >= `GSR_EV_100 && c < `GSR_EV_200) begin
                cat_of = `GSR_STB_CMD;
            end else if (c >= `GSR_EV_200 && c < `GSR_EV_300) begin
                cat_of = `GSR_STB_EXEC;
            end else if (c >= `GSR_EV_300 && c < `GSR_EV_400) begin
                cat_of = `GSR_STB_INT;
            end else if (c >= `GSR_EV_700 && c < `GSR_EV_800) begin
                cat_of = `GSR_STB_DEV;
            end else begin
                cat_of = `GSR_STB_NONE;
            end
        end
    endfunction

    // Completion codes and five device-dependent events (742, 750, 751, 753, 754) share the one completion mask.
    function is_done_ev;
        input [9:0] c;
        begin
            is_done_ev = (c == `GSR_EV_MEAS) ||
                (c == `GSR_EV_SWEEP) ||
                (c == `GSR_EV_DISK) ||
                (c == `GSR_EV_LRS) ||
                (c == `GSR_EV_ILOCK) ||
                (c == `GSR_EV_BRKR) ||
                (c == `GSR_EV_DISK2) ||
                (c == `GSR_EV_RESUME);
        end
    endfunction

    // APB decode; the slave never waits.
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pwrite;
    assign pready = 1'b1;

    always @* begin
        addr_ok = 1'b1;
        rd_nxt = 32'h00000000;
        case (paddr)
            `GSR_OFF_CTRL: begin
                rd_nxt[`GSR_CTRL_SRQ_EN] = srq_en_r;
                rd_nxt[`GSR_CTRL_DONE_EN] = done_en_r;
            end
            `GSR_OFF_STATUS: begin
                rd_nxt = {24'h000000, cnt_r, gap_r, pend_v_r, cur_v_r, srq};
            end
            `GSR_OFF_STB: begin
                rd_nxt = {24'h000000, cur_v_r ? cur_r : `GSR_STB_NONE};
            end
            `GSR_OFF_POST: begin
                rd_nxt = {22'h000000, post_code_r};
            end
            `GSR_OFF_TOP: begin
                rd_nxt = {22'h000000, top_code};
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    assign pslverr = psel & penable & ~addr_ok;

    // Read data is captured in the setup cycle so it is stable for the access cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (apb_setup && !pwrite) begin
            prdata <= rd_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srq_en_r <= `GSR_RST_SRQ_EN;
            done_en_r <= `GSR_RST_DONE_EN;
            post_code_r <= `GSR_EV_NONE;
        end else if (apb_wr && paddr == `GSR_OFF_CTRL) begin
            srq_en_r <= pwdata[`GSR_CTRL_SRQ_EN];
            done_en_r <= pwdata[`GSR_CTRL_DONE_EN];
        end else if (apb_wr && paddr == `GSR_OFF_POST) begin
            post_code_r <= pwdata[9:0];
        end
    end

    // Edge detection of front-panel and fault levels.
    // The detectors reset to the idle low level, so no false edge follows reset.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_prev_r <= 1'b0;
            pll_prev_r <= 1'b0;
            heat_prev_r <= 1'b0;
        end else begin
            single_prev_r <= single_btn;
            pll_prev_r <= pll_fault;
            heat_prev_r <= overheat_fault;
        end
    end

    // Source requests, index 0 first: power-on, posted, recovery, user, measure, sweep, print.
    wire [NSRC-1:0] src_set;
    assign src_set[0] = 1'b0;
    assign src_set[1] = apb_wr && paddr == `GSR_OFF_POST;
    assign src_set[2] = (pll_prev_r & ~pll_fault) | (heat_prev_r & ~overheat_fault);
    assign src_set[3] = single_btn & ~single_prev_r & fast_shift_btn;
    assign src_set[4] = meas_done;
    assign src_set[5] = sweep_done;
    assign src_set[6] = print_done;

    always @* begin
        pick = {NSRC{1'b0}};
        for (k = NSRC - 1; k >= 0; k = k - 1) begin
            if (pend_r[k]) begin
                pick = {NSRC{1'b0}};
                pick[k] = 1'b1;
            end
        end
        ev_fire = |pend_r;
        case (pick)
            7'h01: begin
                ev_code = `GSR_EV_PON;
            end
            7'h02: begin
                ev_code = post_code_r;
            end
            7'h04: begin
                ev_code = `GSR_EV_RECOV;
            end
            7'h08: begin
                ev_code = `GSR_EV_USER;
            end
            7'h10: begin
                ev_code = `GSR_EV_MEAS;
            end
            7'h20: begin
                ev_code = `GSR_EV_SWEEP;
            end
            7'h40: begin
                ev_code = `GSR_EV_PRINT;
            end
            default: begin
                ev_code = `GSR_EV_NONE;
            end
        endcase
    end

    // One event is issued per cycle; a new set in the issuing cycle keeps the flag.
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
            reg flag_r;
            assign pend_r[gi] = flag_r;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_r <= (gi == 0) ? 1'b1 : 1'b0;
                end else if (src_set[gi]) begin
                    flag_r <= 1'b1;
                end else if (pick[gi]) begin
                    flag_r <= 1'b0;
                end
            end
        end
    endgenerate

    // A masked completion still enters the code store but gets no status byte.
    wire [7:0] ev_cat = cat_of(ev_code);
    wire ev_load = ev_fire && ev_cat != `GSR_STB_NONE && (done_en_r || !is_done_ev(ev_code));

    always @* begin
        cur_v_nxt = cur_v_r;
        cur_nxt = cur_r;
        pend_v_nxt = pend_v_r;
        pnd_nxt = pnd_r;
        if (spoll_req) begin
            cur_v_nxt = pend_v_r;
            cur_nxt = pnd_r;
            pend_v_nxt = 1'b0;
        end
        if (ev_load) begin
            if (!cur_v_nxt) begin
                cur_v_nxt = 1'b1;
                cur_nxt = ev_cat;
            end else begin
                pend_v_nxt = 1'b1;
                pnd_nxt = ev_cat;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_v_r <= 1'b0;
            cur_r <= `GSR_STB_NONE;
            pend_v_r <= 1'b0;
            pnd_r <= `GSR_STB_NONE;
            gap_r <= 1'b0;
            spoll_byte <= `GSR_STB_NONE;
            spoll_valid <= 1'b0;
        end else begin
            cur_v_r <= cur_v_nxt;
            cur_r <= cur_nxt;
            pend_v_r <= pend_v_nxt;
            pnd_r <= pnd_nxt;
            gap_r <= spoll_req;
            spoll_valid <= spoll_req;
            if (spoll_req) begin
                // The request bit is rebuilt at poll time, so it follows the enable then in force.
                if (cur_v_r) begin
                    spoll_byte <= (cur_r & ~`GSR_STB_SRQ_BIT) |
                        (srq_en_r ? `GSR_STB_SRQ_BIT : `GSR_STB_NONE);
                end else begin
                    spoll_byte <= `GSR_STB_NONE;
                end
            end
        end
    end

    // The one-cycle gap after a poll lets the controller see the line drop between events.
    assign srq = cur_v_r & srq_en_r & ~gap_r;

    // Event code store; entry 0 is the oldest.
    wire [10*10-1:0] flat;
    wire pop_ok = evq_req && cnt_r != 4'h0;
    wire full = cnt_r == `GSR_DEPTH;
    wire [3:0] top_idx = cnt_r - 4'h1;
    // The newest entry is read for queries, which pop it, and for the bus, which does not.
    assign top_code = (cnt_r != 4'h0) ? flat[top_idx*10 +: 10] : `GSR_EV_NONE;

    generate
        for (gi = 0; gi < 10; gi = gi + 1) begin : g_ent
            reg [9:0] ent_r;
            wire [9:0] above;
            if (gi == 9) begin : g_last
                assign above = ev_code;
            end else begin : g_mid
                assign above = flat[(gi+1)*10 +: 10];
            end
            assign flat[gi*10 +: 10] = ent_r;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ent_r <= `GSR_EV_NONE;
                end else if (ev_fire) begin
                    if (pop_ok) begin
                        if (top_idx == gi) begin
                            ent_r <= ev_code;
                        end
                    end else if (full) begin
                        ent_r <= above;
                    end else if (cnt_r == gi) begin
                        ent_r <= ev_code;
                    end
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
            evq_code <= `GSR_EV_NONE;
            evq_valid <= 1'b0;
        end else begin
            // An empty store answers a query with zero and keeps its count.
            evq_valid <= evq_req;
            if (evq_req) begin
                evq_code <= top_code;
            end
            if (ev_fire && !pop_ok && !full) begin
                cnt_r <= cnt_r + 4'h1;
            end else if (pop_ok && !ev_fire) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end

endmodule // gsr_reporter

// ### tb/gsr_ctrl_model.sv
`timescale 1ns/10ps
module gsr_ctrl_model (
    // Clock
    input wire pclk,
    // Poll and query
    output logic spoll_req,
    input wire [7:0] spoll_byte,
    input wire spoll_valid,
    output logic evq_req,
    input wire [9:0] evq_code,
    input wire evq_valid
);
    initial begin
        spoll_req = 1'b0;
        evq_req = 1'b0;
    end
    // Serial poll: one-cycle request, answer taken one edge later.
    task poll(output logic v, output logic [7:0] b);
        @(posedge pclk);
        spoll_req <= 1'b1;
        @(posedge pclk);
        spoll_req <= 1'b0;
        @(posedge pclk);
        v = spoll_valid;
        b = spoll_byte;
    endtask
    task query(output logic v, output logic [9:0] c);
        @(posedge pclk);
        evq_req <= 1'b1;
        @(posedge pclk);
        evq_req <= 1'b0;
        @(posedge pclk);
        v = evq_valid;
        c = evq_code;
    endtask
endmodule // gsr_ctrl_model

// ### tb/gsr_reporter_asserts.sv
`timescale 1ns/10ps
`include "gsr_consts.vh"
module gsr_reporter_asserts (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Controller side
    input wire srq,
    input wire spoll_req,
    input wire [7:0] spoll_byte,
    input wire spoll_valid,
    input wire evq_req,
    input wire evq_valid
);
    // Shadow of the request enable, so the checker needs nothing inside the block.
    logic en_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            en_r <= `GSR_RST_SRQ_EN;
        else if (psel && penable && pwrite && paddr == `GSR_OFF_CTRL)
            en_r <= pwdata[`GSR_CTRL_SRQ_EN];
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    poll_answer_a: assert property (spoll_req |=> spoll_valid)
        else $error("poll not answered in one cycle");
    poll_only_a: assert property (!spoll_req |=> !spoll_valid)
        else $error("poll answer without a poll");
    query_answer_a: assert property (evq_req |=> evq_valid)
        else $error("query not answered in one cycle");
    query_only_a: assert property (!evq_req |=> !evq_valid)
        else $error("query answer without a query");
    srq_drop_a: assert property (spoll_valid |-> !srq)
        else $error("request held through poll answer");
    srq_masked_a: assert property (!en_r |-> !srq)
        else $error("request raised while disabled");
    byte_flag_a: assert property (spoll_valid && !$past(en_r) |-> !spoll_byte[6])
        else $error("request bit set while disabled");
    zero_wait_a: assert property (psel |-> pready)
        else $error("wait state inserted");
    unmapped_err_a: assert property (psel && penable && paddr > `GSR_OFF_TOP |-> pslverr)
        else $error("unmapped access not refused");
endmodule // gsr_reporter_asserts

// ### tb/gsr_tb.sv
`timescale 1ns/10ps
`include "gsr_consts.vh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic srq, spoll_req, spoll_valid, evq_req, evq_valid;
    logic [7:0] spoll_byte;
    logic [9:0] evq_code;
    logic [2:0] done_v;
    logic single_btn, fast_shift_btn, pll_fault, overheat_fault;
    int n_fail, num_checks, cyc;
    gsr_reporter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .srq(srq), .spoll_req(spoll_req), .spoll_byte(spoll_byte),
        .spoll_valid(spoll_valid), .evq_req(evq_req), .evq_code(evq_code),
        .evq_valid(evq_valid), .meas_done(done_v[0]), .sweep_done(done_v[1]),
        .print_done(done_v[2]), .single_btn(single_btn), .fast_shift_btn(fast_shift_btn),
        .pll_fault(pll_fault), .overheat_fault(overheat_fault));
    gsr_ctrl_model ctl_u (.pclk(pclk), .spoll_req(spoll_req), .spoll_byte(spoll_byte),
        .spoll_valid(spoll_valid), .evq_req(evq_req), .evq_code(evq_code),
        .evq_valid(evq_valid));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // A hang costs at most a few thousand cycles; the tests need well under one thousand.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task post(input logic [9:0] c);
        apb(1'b1, `GSR_OFF_POST, {22'h0, c});
        repeat (2) @(posedge pclk);
    endtask
    task pulse(input logic [2:0] m);
        @(posedge pclk);
        done_v <= m;
        @(posedge pclk);
        done_v <= 3'h0;
        repeat (3) @(posedge pclk);
    endtask
    task poll_chk(input logic [7:0] b);
        logic v;
        logic [7:0] sb;
        ctl_u.poll(v, sb);
        check("poll valid", 32'(v), 32'h1);
        check("status byte", 32'(sb), 32'(b));
    endtask
    task query_chk(input logic [9:0] c);
        logic v;
        logic [9:0] ec;
        ctl_u.query(v, ec);
        check("query valid", 32'(v), 32'h1);
        check("event code", 32'(ec), 32'(c));
    endtask
    task both(input logic [7:0] b, input logic [9:0] c);
        poll_chk(b);
        query_chk(c);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, done_v} = '0;
        {single_btn, fast_shift_btn, pll_fault, overheat_fault} = 4'h0;
        {n_fail, num_checks, cyc} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        check("srq", 32'(srq), 32'h1);
        apb(1'b0, `GSR_OFF_CTRL, 32'h0);
        check("ctrl", q, 32'h3);
        apb(1'b1, 8'h14, 32'hFFFFFFFF);
        check("slverr", 32'(e), 32'h1);
        both(8'h41, 10'h191);
        both(8'h00, 10'h000);
        $display("power-on test done");
        pulse(3'h1);
        check("srq", 32'(srq), 32'h1);
        both(8'h42, 10'h192);
        apb(1'b1, `GSR_OFF_CTRL, 32'h1);
        pulse(3'h2);
        check("srq", 32'(srq), 32'h0);
        query_chk(10'h196);
        apb(1'b0, `GSR_OFF_CTRL, 32'h0);
        check("ctrl", q, 32'h1);
        apb(1'b1, `GSR_OFF_CTRL, 32'h3);
        $display("completion test done");
        post(10'h065);
        post(10'h0C9);
        post(10'h12F);
        poll_chk(8'h61);
        @(posedge pclk);
        check("srq", 32'(srq), 32'h1);
        poll_chk(8'h63);
        poll_chk(8'h00);
        query_chk(10'h12F);
        query_chk(10'h0C9);
        query_chk(10'h065);
        $display("pending test done");
        apb(1'b1, `GSR_OFF_CTRL, 32'h2);
        for (int i = 0; i < 11; i++)
            post(10'h065 + 10'(i));
        check("srq", 32'(srq), 32'h0);
        poll_chk(8'h21);
        for (int i = 0; i < 10; i++)
            query_chk(10'h06F - 10'(i));
        query_chk(10'h000);
        apb(1'b1, `GSR_OFF_CTRL, 32'h3);
        poll_chk(8'h61);
        poll_chk(8'h00);
        $display("store test done");
        fast_shift_btn <= 1'b1;
        @(posedge pclk);
        single_btn <= 1'b1;
        repeat (3) @(posedge pclk);
        {single_btn, fast_shift_btn} <= 2'h0;
        both(8'h43, 10'h193);
        {pll_fault, overheat_fault} <= 2'h3;
        repeat (2) @(posedge pclk);
        pll_fault <= 1'b0;
        repeat (3) @(posedge pclk);
        both(8'h45, 10'h195);
        overheat_fault <= 1'b0;
        repeat (3) @(posedge pclk);
        both(8'h45, 10'h195);
        pulse(3'h4);
        both(8'h44, 10'h194);
        post(10'h0C9);
        both(8'h62, 10'h0C9);
        post(10'h2EE);
        both(8'hC0, 10'h2EE);
        $display("source test done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        check("srq", 32'(srq), 32'h1);
        both(8'h41, 10'h191);
        $display("reset test done");
        wrap_up();
    end
endmodule // tb
bind gsr_reporter gsr_reporter_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .srq(srq), .spoll_req(spoll_req),
    .spoll_byte(spoll_byte), .spoll_valid(spoll_valid), .evq_req(evq_req),
    .evq_valid(evq_valid));
